// >>> bench/fault_logic_bench.sv
// Self-checking bench for the overcurrent / undervoltage fault logic
`timescale 1ns/100ps
module fault_logic_bench;
  import fault_logic_pkg::*;
  logic clk, resetn, directIn, spiOutputOn, flagRead, highSel, uvDisable, groundLost, otherFault;
  logic gateEnable, statusN, uvFlag, ocFault, highLevelSel;
  logic [2:0] lowSel, lowLevelSel;
  logic [1:0] filtSel;
  oc_compare_t ocCompare;
  supply_band_t supplyBand;
  int failures = 0;
  int comparisons = 0;
  host_model i_host (.clk(clk), .directIn(directIn), .spiOutputOn(spiOutputOn), .flagRead(flagRead));
  fault_logic i_dut (.clk(clk), .resetn(resetn), .directIn(directIn), .spiOutputOn(spiOutputOn),
    .overcurrent_low_threshold(lowSel), .overcurrent_high_threshold(highSel),
    .overcurrent_filter_time(filtSel), .undervoltage_protect_disable(uvDisable), .ocCompare(ocCompare),
    .supplyBand(supplyBand), .groundLost(groundLost), .otherFault(otherFault), .flagRead(flagRead),
    .gateEnable(gateEnable), .fault_status_pin_n(statusN), .undervoltage_flag(uvFlag),
    .overcurrentFault(ocFault), .lowLevelSel(lowLevelSel), .highLevelSel(highLevelSel));
  // ----------------------------------------
  // Reference model from the rules, one clock behind the inputs like the pins
  // ----------------------------------------
  int filterCycles[$] = {FILT_US0 * CLK_MHZ, FILT_US1 * CLK_MHZ, FILT_US2 * CLK_MHZ, FILT_US3 * CLK_MHZ};
  int mOc, mUv, mCnt, mGate, mStatusN, mFlag;
  always @(posedge clk or negedge resetn) begin : ref_model
    int cmd;
    int uvOn;
    int oc;
    int uv;
    if (!resetn) begin
      mOc <= 0;
      mUv <= 0;
      mCnt <= 0;
      mGate <= 0;
      mStatusN <= 1;
      mFlag <= 0;
    end else begin
      cmd = directIn || spiOutputOn;
      uvOn = !uvDisable;
      // High level latches at once; low level only once held longer than the filter time
      oc = (mGate && (ocCompare.atHigh || (ocCompare.atLow && mCnt > filterCycles[filtSel]))) || (mOc && cmd);
      uv = uvOn && cmd && (supplyBand != SUP_NORMAL || mUv);
      mCnt <= (mGate && ocCompare.atLow) ? mCnt + 1 : 0;
      mOc <= oc;
      mUv <= uv;
      mFlag <= uvOn && (supplyBand != SUP_NORMAL || (mFlag && !flagRead));
      mGate <= cmd && !oc && !mUv && !(uvOn && supplyBand != SUP_NORMAL) && supplyBand != SUP_DEAD && !groundLost;
      mStatusN <= !(oc || otherFault || (uvOn && supplyBand == SUP_UV)
        || (uvOn && uv && supplyBand == SUP_NORMAL));
    end
  end
  // ----------------------------------------
  // Clock, stimulus and checking helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every gate, status, flag and fault result is also held against the reference model
  task automatic modelChk();
    chk("gateEnable", 3'(mGate), {2'h0, gateEnable});
    chk("fault_status_pin_n", 3'(mStatusN), {2'h0, statusN});
    chk("undervoltage_flag", 3'(mFlag), {2'h0, uvFlag});
    chk("overcurrentFault", 3'(mOc), {2'h0, ocFault});
  endtask
  // Let the sampling edge and the register edge both pass before looking
  task automatic waitn(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic outs(input logic g, input logic s, input logic f);
    waitn(2);
    chk("gateEnable", {2'h0, g}, {2'h0, gateEnable});
    chk("fault_status_pin_n", {2'h0, s}, {2'h0, statusN});
    chk("undervoltage_flag", {2'h0, f}, {2'h0, uvFlag});
    modelChk();
  endtask
  task automatic band(input supply_band_t b);
    @(posedge clk);
    supplyBand <= b;
  endtask
  task automatic current(input logic lo, input logic hi);
    @(posedge clk);
    ocCompare <= '{atLow: lo, atHigh: hi};
  endtask
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog: about 80000 cycles are needed, nearly all in the two longest filter runs
  initial begin
    #(40 * 90000);
    failures++;
    end_of_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {resetn, lowSel, highSel, filtSel, uvDisable, groundLost, otherFault} = '0;
    ocCompare = '{atLow: 1'b0, atHigh: 1'b0};
    supplyBand = SUP_NORMAL;
    void'($urandom(3080));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    outs(1'b0, 1'b1, 1'b0);
    // Every low level and a random high level reach the sense comparators
    for (int i = 0; i < LOW_LEVELS; i++) begin
      @(posedge clk);
      lowSel <= 3'(i);
      highSel <= 1'($urandom);
      waitn(2);
      chk("lowLevelSel", 3'(i), lowLevelSel);
      chk("highLevelSel", {2'h0, highSel}, {2'h0, highLevelSel});
    end
    i_host.command(1'b1, 1'b1);
    outs(1'b1, 1'b1, 1'b0);
    i_host.command(1'b1, 1'b0);
    outs(1'b1, 1'b1, 1'b0);
    // High trip cuts the gate at once and holds until off then on
    current(1'b0, 1'b1);
    outs(1'b0, 1'b0, 1'b0);
    chk("overcurrentFault", 3'h1, {2'h0, ocFault});
    current(1'b0, 1'b0);
    outs(1'b0, 1'b0, 1'b0);
    i_host.toggle();
    outs(1'b1, 1'b1, 1'b0);
    // Low trip: a gap restarts the 250-cycle filter, a steady run latches
    current(1'b1, 1'b0);
    waitn(200);
    current(1'b0, 1'b0);
    current(1'b1, 1'b0);
    waitn(200);
    chk("gateEnable", 3'h1, {2'h0, gateEnable});
    modelChk();
    waitn(60);
    chk("gateEnable", 3'h0, {2'h0, gateEnable});
    chk("overcurrentFault", 3'h1, {2'h0, ocFault});
    modelChk();
    current(1'b0, 1'b0);
    i_host.toggle();
    outs(1'b1, 1'b1, 1'b0);
    // Longer filter codes: still on at the limit, latched four cycles past it
    for (int code = 1; code < 4; code++) begin
      @(posedge clk);
      filtSel <= 2'(code);
      current(1'b1, 1'b0);
      waitn(filterCycles[code]);
      chk("gateEnable", 3'h1, {2'h0, gateEnable});
      waitn(4);
      chk("overcurrentFault", 3'h1, {2'h0, ocFault});
      modelChk();
      current(1'b0, 1'b0);
      i_host.toggle();
      outs(1'b1, 1'b1, 1'b0);
    end
    @(posedge clk);
    otherFault <= 1'b1;
    outs(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    otherFault <= 1'b0;
    groundLost <= 1'b1;
    outs(1'b0, 1'b1, 1'b0);
    @(posedge clk);
    groundLost <= 1'b0;
    i_host.toggle();
    outs(1'b1, 1'b1, 1'b0);
    // Undervoltage while commanded on latches the output off
    band(SUP_UV);
    outs(1'b0, 1'b0, 1'b1);
    band(SUP_POR);
    outs(1'b0, 1'b1, 1'b1);
    band(SUP_NORMAL);
    outs(1'b0, 1'b0, 1'b1);
    i_host.toggle();
    outs(1'b1, 1'b1, 1'b1);
    i_host.readFlag();
    outs(1'b1, 1'b1, 1'b0);
    // Commanded off: not latched, a read during the dip is ignored
    i_host.command(1'b0, 1'b0);
    band(SUP_UV);
    outs(1'b0, 1'b0, 1'b1);
    i_host.readFlag();
    outs(1'b0, 1'b0, 1'b1);
    band(SUP_NORMAL);
    outs(1'b0, 1'b1, 1'b1);
    i_host.readFlag();
    outs(1'b0, 1'b1, 1'b0);
    // Protection disabled: output rides the dip, off only when dead
    @(posedge clk);
    uvDisable <= 1'b1;
    i_host.command(1'b1, 1'b1);
    band(SUP_UV);
    outs(1'b1, 1'b1, 1'b0);
    band(SUP_DEAD);
    outs(1'b0, 1'b1, 1'b0);
    band(SUP_NORMAL);
    outs(1'b1, 1'b1, 1'b0);
    end_of_test();
  end
endmodule

// >>> bench/host_model.sv
// Host controller model: output command sources and flag read strobe
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  output logic directIn,
  output logic spiOutputOn,
  output logic flagRead
);
  initial begin
    directIn = 1'b0;
    spiOutputOn = 1'b0;
    flagRead = 1'b0;
  end
  // Command through one source only, so the OR in the device is exercised
  task automatic command(input logic on, input logic viaSpi);
    @(posedge clk);
    directIn <= on & ~viaSpi;
    spiOutputOn <= on & viaSpi;
  endtask
  // Off for two sampled cycles, then on again: the only way out of a latch
  task automatic toggle();
    command(1'b0, 1'b0);
    @(posedge clk);
    command(1'b1, 1'b0);
  endtask
  // Read strobe lasts exactly one cycle
  task automatic readFlag();
    @(posedge clk);
    flagRead <= 1'b1;
    @(posedge clk);
    flagRead <= 1'b0;
  endtask
endmodule

// >>> hw/fault_logic.sv
// Overcurrent and undervoltage fault handling for a high-side switch
`timescale 1ns/100ps
module fault_logic (
  input wire logic clk,
  input wire logic resetn,
  input wire logic directIn,
  input wire logic spiOutputOn,
  input wire logic [fault_logic_pkg::LOW_SEL_W-1:0] overcurrent_low_threshold,
  input wire logic overcurrent_high_threshold,
  input wire logic [1:0] overcurrent_filter_time,
  input wire logic undervoltage_protect_disable,
  input wire fault_logic_pkg::oc_compare_t ocCompare,
  input wire fault_logic_pkg::supply_band_t supplyBand,
  input wire logic groundLost,
  input wire logic otherFault,
  input wire logic flagRead,
  output logic gateEnable,
  output logic fault_status_pin_n,
  output logic undervoltage_flag,
  output logic overcurrentFault,
  output logic [fault_logic_pkg::LOW_SEL_W-1:0] lowLevelSel,
  output logic highLevelSel
);
  import fault_logic_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    oc_state_t ocState;
    logic ocFault;
    logic cmdPrev;
    logic uvLatched;
    logic uvFlag;
    logic gate;
    logic statusN;
    logic [LOW_SEL_W-1:0] lowSel;
    logic highSel;
  } fault_state_t;

  localparam fault_state_t STATE_RESET = '{ocState: OC_RESET, ocFault: 1'b0, cmdPrev: 1'b0, uvLatched: 1'b0,
    uvFlag: 1'b0, gate: 1'b0, statusN: 1'b1, lowSel: '0, highSel: 1'b0};

  fault_state_t state_q, state_d;

  logic command;
  logic cmdRise;
  logic filterExpired;
  logic filterRun;
  logic uvActive;
  logic [FILT_W-1:0] filterLimit;

  // Filter time select decoded to a cycle count
  function automatic logic [FILT_W-1:0] filter_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: filter_cycles = FILT_CYC0;
      2'h1: filter_cycles = FILT_CYC1;
      2'h2: filter_cycles = FILT_CYC2;
      default: filter_cycles = FILT_CYC3;
    endcase
  endfunction

  // ----------------------------------------
  // Command and detection terms
  // ----------------------------------------
  assign command = directIn | spiOutputOn;
  assign cmdRise = command && !state_q.cmdPrev;
  assign uvActive = !undervoltage_protect_disable;
  // Filter only runs while the gate is on; an off output cannot carry load current
  assign filterRun = state_q.gate && ocCompare.atLow;
  assign filterLimit = filter_cycles(overcurrent_filter_time);

  oc_filter #(
    .WIDTH(FILT_W)
  ) u_filter (
    .clk(clk),
    .resetn(resetn),
    .enable(filterRun),
    .limit(filterLimit),
    .expired(filterExpired)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.cmdPrev = command;
    // Selected levels go to the analogue comparators
    state_d.lowSel = overcurrent_low_threshold;
    state_d.highSel = overcurrent_high_threshold;

    // Overcurrent latch; both thresholds watched at once
    case (state_q.ocState)
      OC_IDLE: begin
        if (state_q.gate && ocCompare.atHigh) begin
          state_d.ocState = OC_LATCHED;
        end else if (filterRun) begin
          state_d.ocState = OC_FILTER;
        end
      end
      OC_FILTER: begin
        if (state_q.gate && ocCompare.atHigh) begin
          state_d.ocState = OC_LATCHED;
        end else if (filterExpired) begin
          state_d.ocState = OC_LATCHED;
        end else if (!filterRun) begin
          state_d.ocState = OC_IDLE;
        end
      end
      OC_LATCHED: begin
        if (!command) begin
          state_d.ocState = OC_IDLE;
        end
      end
      default: state_d.ocState = OC_IDLE;
    endcase
    // Registered copy, so the latched-fault output comes straight from a flop
    state_d.ocFault = (state_d.ocState == OC_LATCHED);

    // Undervoltage latch: set only when the output was commanded on
    if (!uvActive) begin
      state_d.uvLatched = 1'b0;
    end else if (supplyBand != SUP_NORMAL && command) begin
      state_d.uvLatched = 1'b1;
    end else if (!command) begin
      state_d.uvLatched = 1'b0;
    end

    // Flag: set wins over a read; a read clears only once supply is back
    if (!uvActive) begin
      state_d.uvFlag = 1'b0;
    end else if (supplyBand != SUP_NORMAL) begin
      state_d.uvFlag = 1'b1;
    end else if (flagRead) begin
      state_d.uvFlag = 1'b0;
    end

    // Gate: the latched off state holds until a fresh rising command
    state_d.gate = command && (state_d.ocState != OC_LATCHED) && !state_q.uvLatched
      && !(uvActive && supplyBand != SUP_NORMAL) && (supplyBand != SUP_DEAD)
      && !groundLost;
    if (uvActive && state_q.uvLatched && !cmdRise) begin
      state_d.gate = 1'b0;
    end
    if (state_q.ocState == OC_LATCHED) begin
      state_d.gate = 1'b0;
    end

    // Status pin low while a fault is being reported
    state_d.statusN = !((state_d.ocState == OC_LATCHED) || otherFault
      || (uvActive && supplyBand == SUP_UV)
      || (uvActive && state_d.uvLatched && supplyBand == SUP_NORMAL));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign gateEnable = state_q.gate;
  assign fault_status_pin_n = state_q.statusN;
  assign undervoltage_flag = state_q.uvFlag;
  assign overcurrentFault = state_q.ocFault;
  assign lowLevelSel = state_q.lowSel;
  assign highLevelSel = state_q.highSel;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_high_trip;
    gateEnable && ocCompare.atHigh;
  endsequence

  sequence s_latched_off;
    overcurrentFault && !gateEnable;
  endsequence

  a_high_trip_off: assert property (@(posedge clk) disable iff (!resetn)
    s_high_trip |=> s_latched_off) else $error("high trip did not latch off");
  a_latch_holds: assert property (@(posedge clk) disable iff (!resetn)
    overcurrentFault && command |=> overcurrentFault) else $error("latch released without off");
  a_latch_gate_off: assert property (@(posedge clk) disable iff (!resetn)
    overcurrentFault |-> !gateEnable && !fault_status_pin_n) else $error("latched fault not off");
  a_ground_off: assert property (@(posedge clk) disable iff (!resetn)
    groundLost |=> !gateEnable) else $error("ground loss left output on");
  a_uvdis_quiet: assert property (@(posedge clk) disable iff (!resetn)
    undervoltage_protect_disable |=> !undervoltage_flag) else $error("flag set while disabled");
  a_uv_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    uvActive && supplyBand == SUP_UV |=> undervoltage_flag && !fault_status_pin_n && !gateEnable)
    else $error("undervoltage not reported");
  a_por_pin_high: assert property (@(posedge clk) disable iff (!resetn)
    uvActive && supplyBand == SUP_POR && !otherFault && !overcurrentFault ##1 !overcurrentFault
    |-> fault_status_pin_n && !gateEnable) else $error("pin low below POR");
  a_cmd_follow: assert property (@(posedge clk) disable iff (!resetn)
    undervoltage_protect_disable && supplyBand != SUP_DEAD && !groundLost && !command
    |=> !gateEnable) else $error("output on without command");
  // Filter expiry, and a recovered supply while the command is still on
  a_low_trip_off: assert property (@(posedge clk) disable iff (!resetn)
    (state_q.ocState == OC_FILTER) && filterExpired |=> s_latched_off) else $error("low trip did not latch off");
  a_uv_hold_off: assert property (@(posedge clk) disable iff (!resetn)
    uvActive && state_q.uvLatched && command && supplyBand == SUP_NORMAL
    |=> !gateEnable && !fault_status_pin_n) else $error("recovered supply released the latch");
endmodule

// >>> hw/fault_logic_pkg.sv
// Package: constants and carrier types for the overcurrent / undervoltage fault logic
package fault_logic_pkg;

  // ----------------------------------------
  // Threshold selection
  // ----------------------------------------
  localparam int LOW_LEVELS = 8;
  localparam int HIGH_LEVELS = 2;
  localparam int LOW_SEL_W = 3;

  // ----------------------------------------
  // Filter timing (internal oscillator tick = one clk at 25 MHz)
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int FILT_W = 16;
  // Filter times in microseconds per code of the 2-bit filter select
  localparam int FILT_US0 = 10;
  localparam int FILT_US1 = 100;
  localparam int FILT_US2 = 1000;
  localparam int FILT_US3 = 2000;
  localparam logic [FILT_W-1:0] FILT_CYC0 = FILT_W'(FILT_US0 * CLK_MHZ);
  localparam logic [FILT_W-1:0] FILT_CYC1 = FILT_W'(FILT_US1 * CLK_MHZ);
  localparam logic [FILT_W-1:0] FILT_CYC2 = FILT_W'(FILT_US2 * CLK_MHZ);
  localparam logic [FILT_W-1:0] FILT_CYC3 = FILT_W'(FILT_US3 * CLK_MHZ);

  // ----------------------------------------
  // Supply band encoding from the comparators
  // ----------------------------------------
  typedef enum logic [1:0] {
    SUP_NORMAL = 2'h0,  // Above undervoltage threshold
    SUP_UV = 2'h1,      // Between undervoltage and POR threshold
    SUP_POR = 2'h2,     // Between POR threshold and about 2.5 V
    SUP_DEAD = 2'h3     // Below about 2.5 V
  } supply_band_t;

  // Current comparator results, one bit per selected threshold
  typedef struct packed {
    logic atLow;
    logic atHigh;
  } oc_compare_t;

  // Overcurrent latch states
  typedef enum logic [2:0] {
    OC_IDLE = 3'h1,
    OC_FILTER = 3'h2,
    OC_LATCHED = 3'h4
  } oc_state_t;

  localparam oc_state_t OC_RESET = OC_IDLE;

endpackage

// >>> hw/oc_filter.sv
// Overcurrent low-threshold filter timer
`timescale 1ns/100ps
module oc_filter #(
  parameter int WIDTH = fault_logic_pkg::FILT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [WIDTH-1:0] limit,
  output logic expired
);
  import fault_logic_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic expired;
  } filt_state_t;

  filt_state_t state_q, state_d;

  // Counter restarts whenever the current drops below the low level
  always_comb begin
    state_d = state_q;
    if (!enable) begin
      state_d.count = '0;
      state_d.expired = 1'b0;
    end else if (state_q.count >= limit) begin
      state_d.expired = 1'b1;
    end else begin
      state_d.count = state_q.count + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign expired = state_q.expired;

  a_filter_restart: assert property (@(posedge clk) disable iff (!resetn)
    !enable |=> (state_q.count == '0) && !expired) else $error("filter did not restart");
endmodule
